// >>> testbench/ofr_host_model.sv
`timescale 1ns/1ns
module ofr_host_model
(
    // clock
    input  wire logic        ref_clk,
    // command port
    output logic             cmdValid,
    output logic             cmdWrite,
    output logic [7:0]       cmdCode,
    output logic [15:0]      cmdWdata,
    input  wire logic [15:0] rdData,
    input  wire logic        rdValid,
    input  wire logic        cmdErr,
    // clears, on/off and bias
    output logic             faultClear,
    output logic             enablePin,
    output logic             biasGoodPin
);
    initial
    begin
        cmdValid    = 1'b0;
        cmdWrite    = 1'b0;
        cmdCode     = 8'h00;
        cmdWdata    = 16'h0000;
        faultClear  = 1'b0;
        enablePin   = 1'b1;
        biasGoodPin = 1'b1;
    end

    // idle bus is inverted so a stale code or datum never looks valid
    task automatic access(input logic wr, input logic [7:0] code,
                          input logic [15:0] wdata,
                          output logic [15:0] rd, output logic err,
                          output logic vld);
        @(posedge ref_clk);
        #1;
        cmdValid = 1'b1;
        cmdWrite = wr;
        cmdCode  = code;
        cmdWdata = wdata;
        @(posedge ref_clk);
        #1;
        rd       = rdData;
        err      = cmdErr;
        vld      = rdValid;
        cmdValid = 1'b0;
        cmdCode  = ~cmdCode;
        cmdWdata = ~cmdWdata;
    endtask

    task automatic clear_fault();
        @(posedge ref_clk);
        #1;
        faultClear = 1'b1;
        @(posedge ref_clk);
        #1;
        faultClear = 1'b0;
    endtask

    // off then on through the enable pin, or a bias drop
    task automatic off_on(input logic viaBias);
        if (viaBias)
            biasGoodPin = 1'b0;
        else
            enablePin = 1'b0;
        repeat (6) @(posedge ref_clk);
        #1;
        biasGoodPin = 1'b1;
        enablePin   = 1'b1;
    endtask
endmodule

// >>> testbench/tb_ofr_fault_response.sv
`timescale 1ns/1ns
module tb_ofr_fault_response;
    import ofr_pkg::*;
    localparam logic [15:0] COOL = 16'h0100;
    localparam logic [15:0] HOT  = 16'h0101;
    logic        ref_clk, sys_rst, cmdValid, cmdWrite, rdValid, cmdErr;
    logic [7:0]  cmdCode;
    logic [15:0] cmdWdata, rdData, temperature, timeUnitCycles;
    logic        faultClear, otherFault, enablePin, biasGoodPin;
    logic        outputEnable, otFault, prevOe;
    int          miscompares, checked, cycles, n, rises, unit;

    ofr_host_model host (.ref_clk(ref_clk), .cmdValid(cmdValid),
        .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdWdata(cmdWdata),
        .rdData(rdData), .rdValid(rdValid), .cmdErr(cmdErr),
        .faultClear(faultClear), .enablePin(enablePin),
        .biasGoodPin(biasGoodPin));

    ofr_fault_response dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
        .cmdWdata(cmdWdata), .rdData(rdData), .rdValid(rdValid),
        .cmdErr(cmdErr), .temperature(temperature),
        .timeUnitCycles(timeUnitCycles), .faultClear(faultClear),
        .otherFault(otherFault), .enablePin(enablePin),
        .biasGoodPin(biasGoodPin), .outputEnable(outputEnable),
        .otFault(otFault));

    always #2 ref_clk = ~ref_clk;

    task automatic wrap_up();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp);
        checked++;
        if (got != exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic reg_rd(input logic [7:0] code, input logic [15:0] exp,
                          input logic expErr);
        logic [15:0] d;
        logic        e;
        logic        v;
        host.access(1'b0, code, 16'h0000, d, e, v);
        chk_reg(d, exp);
        chk_reg({15'h0000, e}, {15'h0000, expErr});
        chk_reg({15'h0000, v}, 16'h0001);
    endtask

    task automatic reg_wr(input logic [7:0] code, input logic [15:0] data);
        logic [15:0] d;
        logic        e;
        logic        v;
        host.access(1'b1, code, data, d, e, v);
        chk_reg({15'h0000, e}, 16'h0000);
        chk_reg({15'h0000, v}, 16'h0000);
    endtask

    // counts cycles, this one included, that the output sits at lvl
    task automatic run_len(input logic lvl, input int lim, output int cnt);
        cnt = 0;
        while (cnt < lim && outputEnable === lvl)
        begin
            cnt++;
            @(posedge ref_clk);
            #1;
        end
    endtask

    task automatic recover();
        temperature = COOL;
        host.clear_fault();
        run_len(1'b0, 20, n);
        chk_cnt(int'(n < 20), 1);
    endtask

    initial
    begin
        ref_clk        = 1'b0;
        sys_rst        = 1'b1;
        temperature    = 16'h0000;
        timeUnitCycles = 16'h0002;
        otherFault     = 1'b0;
        repeat (10) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        reg_rd(CMD_REACTION, {8'h00, REACTION_RESET}, 1'b0);
        reg_rd(CMD_OT_LIMIT, LIMIT_RESET, 1'b0);
        reg_rd(8'h51, 16'h0000, 1'b1);
        reg_wr(CMD_REACTION, 16'hFFA5);
        reg_rd(CMD_REACTION, 16'h00A5, 1'b0);
        reg_wr(CMD_OT_LIMIT, COOL);
        reg_rd(CMD_OT_LIMIT, COOL, 1'b0);
        recover();
        $display("registers done");
        reg_wr(CMD_REACTION, 16'h0000);
        temperature = HOT;
        run_len(1'b1, 40, n);
        chk_cnt(n, 40);
        chk_reg({15'h0000, otFault}, 16'h0001);
        recover();
        $display("ignore done");
        // 01, one retry, delay code 2: on N+2, off N+1, one try, latch
        reg_wr(CMD_REACTION, 16'h004A);
        temperature = HOT;
        run_len(1'b1, 400, n);
        chk_cnt(n, (2 << 2) + 2);
        run_len(1'b0, 400, n);
        chk_cnt(n, (2 << 2) + 1);
        run_len(1'b1, 10, n);
        chk_cnt(n, 1);
        run_len(1'b0, 30, n);
        chk_cnt(n, 30);
        recover();
        temperature = HOT;
        repeat (3) @(posedge ref_clk);
        #1;
        temperature = COOL;
        run_len(1'b1, 30, n);
        chk_cnt(n, 30);
        $display("continue done");
        for (int r = 0; r < 8; r++)
        begin
            reg_wr(CMD_REACTION, {8'h00, RESP_DISABLE, r[2:0], 3'h0});
            temperature = HOT;
            rises = 0;
            repeat (120)
            begin
                prevOe = outputEnable;
                @(posedge ref_clk);
                #1;
                if (outputEnable === 1'b1 && prevOe === 1'b0)
                    rises++;
            end
            if (r == 7)
                chk_cnt(int'(rises > 6), 1);
            else
                chk_cnt(rises, r);
            recover();
        end
        $display("retry counts done");
        for (int d = 0; d < 8; d++)
        begin
            unit = d % 3 + 1;
            timeUnitCycles = 16'(unit);
            reg_wr(CMD_REACTION, {8'h00, RESP_DISABLE, RETRY_FOREVER, d[2:0]});
            temperature = HOT;
            run_len(1'b1, 5, n);
            chk_cnt(n, 1);
            temperature = COOL;
            run_len(1'b0, 400, n);
            chk_cnt(n, (unit << d) + 1);
            run_len(1'b1, 10, n);
            chk_cnt(n, 10);
        end
        timeUnitCycles = 16'h0002;
        $display("delays done");
        reg_wr(CMD_REACTION, 16'h00C0);
        for (int m = 0; m < 3; m++)
        begin
            temperature = HOT;
            run_len(1'b1, 5, n);
            chk_cnt(n, 1);
            temperature = COOL;
            run_len(1'b0, 30, n);
            chk_cnt(n, 30);
            if (m == 0)
                host.clear_fault();
            else
                host.off_on(m == 2);
            run_len(1'b0, 20, n);
            chk_cnt(int'(n < 20), 1);
        end
        $display("latch done");
        reg_wr(CMD_REACTION, 16'h00B8);
        otherFault = 1'b1;
        @(posedge ref_clk);
        #1;
        otherFault = 1'b0;
        run_len(1'b0, 30, n);
        chk_cnt(n, 30);
        recover();
        reg_wr(CMD_REACTION, 16'h00C0);
        temperature = HOT;
        repeat (5) @(posedge ref_clk);
        #1;
        sys_rst = 1'b1;
        temperature = COOL;
        @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        reg_rd(CMD_REACTION, {8'h00, REACTION_RESET}, 1'b0);
        run_len(1'b0, 20, n);
        chk_cnt(int'(n < 20), 1);
        $display("other fault and reset done");
        wrap_up();
    end
endmodule

// >>> verilog/ofr_delay_timer.sv
`timescale 1ns/1ns
module ofr_delay_timer
(
    // clock and reset
    input wire logic   ref_clk,
    input wire logic   sys_rst,
    // control side
    ofr_timer_if.timer tmr
);
    import ofr_pkg::*;
    localparam int LW = UNIT_W + DELAY_MAX_SH;

    logic [LW-1:0] remain;
    logic [LW-1:0] loadHeld;
    logic [LW-1:0] elapsed;
    logic          busy;
    logic          expiredQ;
    logic [LW-1:0] loadVal;
    logic [UNIT_W-1:0] unitSafe;

    // zero unit length would end every delay after one cycle, whatever the code; treat it as one cycle
    assign unitSafe = (tmr.unitLen == '0) ? UNIT_W'(1) : tmr.unitLen;
    assign loadVal  = LW'(unitSafe) << tmr.delayCode;
    assign tmr.expired = expiredQ;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            remain   <= '0;
            loadHeld <= '0;
            busy     <= 1'b0;
            expiredQ <= 1'b0;
        end
        else if (tmr.start)
        begin
            remain   <= loadVal;
            loadHeld <= loadVal;
            busy     <= 1'b1;
            expiredQ <= 1'b0;
        end
        else if (busy && remain <= LW'(1))
        begin
            busy     <= 1'b0;
            expiredQ <= 1'b1;
        end
        else
        begin
            remain   <= busy ? remain - LW'(1) : remain;
            expiredQ <= 1'b0;
        end
    end

    // helper for checking only
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            elapsed <= '0;
        else if (tmr.start)
            elapsed <= LW'(1);
        else if (busy)
            elapsed <= elapsed + LW'(1);
    end

    property p_delay_len;
        @(posedge ref_clk) disable iff (sys_rst)
        $rose(expiredQ) |-> elapsed == loadHeld + LW'(1);
    endproperty
    a_delay_len: assert property (p_delay_len)
        else $error("delay expired at wrong cycle");
endmodule

// >>> verilog/ofr_fault_response.sv
`timescale 1ns/1ns
module ofr_fault_response
(
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   sys_rst,
    // command port
    input  wire logic                   cmdValid,
    input  wire logic                   cmdWrite,
    input  wire logic [7:0]             cmdCode,
    input  wire logic [15:0]            cmdWdata,
    output logic      [15:0]            rdData,
    output logic                        rdValid,
    output logic                        cmdErr,
    // fault sources, delay unit and clears
    input  wire logic [15:0]            temperature,
    input  wire logic [ofr_pkg::UNIT_W-1:0] timeUnitCycles,
    input  wire logic                   faultClear,
    input  wire logic                   otherFault,
    input  wire logic                   enablePin,
    input  wire logic                   biasGoodPin,
    // power stage and status
    output logic                        outputEnable,
    output logic                        otFault
);
    import ofr_pkg::*;

    logic [7:0]  reaction;
    logic [15:0] otLimit;
    logic [1:0]  enSync;
    logic [1:0]  biasSync;
    logic        runOk;
    logic        overTemp;
    logic [1:0]  respField;
    logic [2:0]  retryField;
    logic [2:0]  retryCount;
    logic        canRetry;
    ofr_state_e  state;
    ofr_state_e  next_state;
    logic        bumpRetry;
    logic        startTimer;
    ofr_timer_if tmrIf ();

    ofr_delay_timer u_timer
    (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .tmr     (tmrIf.timer)
    );

    assign respField  = reaction[RESP_HI:RESP_LO];
    assign retryField = reaction[RETRY_HI:RETRY_LO];
    assign tmrIf.delayCode = reaction[DELAY_HI:DELAY_LO];
    assign tmrIf.unitLen   = timeUnitCycles;
    assign tmrIf.start     = startTimer;
    assign overTemp = temperature > otLimit;
    assign runOk    = enSync[1] && biasSync[1];

    // control pin and bias monitor are asynchronous
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            enSync   <= '0;
            biasSync <= '0;
        end
        else
        begin
            enSync   <= {enSync[0], enablePin};
            biasSync <= {biasSync[0], biasGoodPin};
        end
    end

    // command port: byte reaction, word limit
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            reaction <= REACTION_RESET;
            otLimit  <= LIMIT_RESET;
            rdData   <= '0;
            rdValid  <= 1'b0;
            cmdErr   <= 1'b0;
        end
        else
        begin
            rdValid <= cmdValid && !cmdWrite;
            cmdErr  <= 1'b0;
            if (cmdValid && cmdCode == CMD_REACTION)
            begin
                if (cmdWrite)
                    reaction <= cmdWdata[7:0];
                else
                    rdData <= {8'h00, reaction};
            end
            else if (cmdValid && cmdCode == CMD_OT_LIMIT)
            begin
                if (cmdWrite)
                    otLimit <= cmdWdata;
                else
                    rdData <= otLimit;
            end
            else if (cmdValid)
            begin
                rdData <= '0;
                cmdErr <= 1'b1;
            end
        end
    end

    // sticky status; a new fault beats a clear in the same cycle
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            otFault <= 1'b0;
        else if (overTemp)
            otFault <= 1'b1;
        else if (faultClear)
            otFault <= 1'b0;
    end

    always_comb
    begin
        if (retryField == RETRY_NONE)
            canRetry = 1'b0;
        else if (retryField == RETRY_FOREVER)
            canRetry = 1'b1;
        else
            canRetry = retryCount < retryField;
    end

    always_comb
    begin
        next_state = state;
        startTimer = 1'b0;
        bumpRetry  = 1'b0;
        if (!runOk)
            next_state = ST_OFF;
        else if (otherFault)
            next_state = ST_LATCHED;
        else
        begin
            case (state)
                ST_OFF:
                    next_state = ST_RUN;
                ST_RUN:
                    if (overTemp)
                    begin
                        case (respField)
                            RESP_IGNORE:
                                next_state = ST_RUN;
                            RESP_CONTINUE:
                            begin
                                next_state = ST_CONT_DELAY;
                                startTimer = 1'b1;
                            end
                            RESP_DISABLE:
                            begin
                                next_state = canRetry ? ST_RETRY_WAIT
                                                      : ST_LATCHED;
                                startTimer = canRetry;
                                bumpRetry  = canRetry;
                            end
                            default:
                                next_state = ST_LATCHED;
                        endcase
                    end
                ST_CONT_DELAY:
                    if (tmrIf.expired && overTemp)
                    begin
                        next_state = canRetry ? ST_RETRY_WAIT
                                              : ST_LATCHED;
                        startTimer = canRetry;
                        bumpRetry  = canRetry;
                    end
                    else if (tmrIf.expired)
                        next_state = ST_RUN;
                ST_RETRY_WAIT:
                    if (tmrIf.expired)
                        next_state = ST_ATTEMPT;
                ST_ATTEMPT:
                    if (overTemp)
                    begin
                        next_state = canRetry ? ST_RETRY_WAIT
                                              : ST_LATCHED;
                        startTimer = canRetry;
                        bumpRetry  = canRetry;
                    end
                    else
                        next_state = ST_RUN;
                default:
                    if (faultClear)
                        next_state = ST_RUN;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state        <= ST_OFF;
            outputEnable <= 1'b0;
        end
        else
        begin
            state        <= next_state;
            outputEnable <= next_state == ST_RUN
                         || next_state == ST_CONT_DELAY
                         || next_state == ST_ATTEMPT;
        end
    end

    // a clean run or a clear starts the retry budget afresh
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            retryCount <= '0;
        else if (next_state == ST_RUN || next_state == ST_OFF)
            retryCount <= '0;
        else if (bumpRetry)
            retryCount <= retryCount + 3'h1;
    end

    property p_ignore;
        @(posedge ref_clk) disable iff (sys_rst)
        (state == ST_RUN && overTemp && respField == RESP_IGNORE && runOk
         && !otherFault) |=> outputEnable;
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("output dropped on ignored fault");

    property p_cont_runs;
        @(posedge ref_clk) disable iff (sys_rst)
        state == ST_CONT_DELAY |-> outputEnable;
    endproperty
    a_cont_runs: assert property (p_cont_runs)
        else $error("output off during continue delay");

    property p_disable_now;
        @(posedge ref_clk) disable iff (sys_rst)
        (state == ST_RUN && overTemp && respField == RESP_DISABLE)
        |=> !outputEnable;
    endproperty
    a_disable_now: assert property (p_disable_now)
        else $error("output not disabled on fault");

    property p_latched_off;
        @(posedge ref_clk) disable iff (sys_rst)
        (state == ST_LATCHED && !faultClear) |=> !outputEnable;
    endproperty
    a_latched_off: assert property (p_latched_off)
        else $error("latched output came back without clear");

    property p_no_retry;
        @(posedge ref_clk) disable iff (sys_rst)
        (state == ST_RUN && overTemp && respField == RESP_DISABLE
         && retryField == RETRY_NONE && runOk && !otherFault)
        |=> state == ST_LATCHED;
    endproperty
    a_no_retry: assert property (p_no_retry)
        else $error("restart attempted with retry disabled");

    property p_retry_bound;
        @(posedge ref_clk) disable iff (sys_rst)
        (retryField != RETRY_FOREVER && state == ST_RETRY_WAIT
         && $stable(reaction)) |-> retryCount <= retryField;
    endproperty
    a_retry_bound: assert property (p_retry_bound)
        else $error("more restarts than programmed");

    property p_forever;
        @(posedge ref_clk) disable iff (sys_rst)
        (state == ST_ATTEMPT && overTemp && retryField == RETRY_FOREVER
         && runOk && !otherFault) |=> state == ST_RETRY_WAIT;
    endproperty
    a_forever: assert property (p_forever)
        else $error("continuous retry stopped");

    property p_clear_count;
        @(posedge ref_clk) disable iff (sys_rst)
        (state == ST_LATCHED && faultClear && runOk && !otherFault)
        |=> retryCount == 3'h0;
    endproperty
    a_clear_count: assert property (p_clear_count)
        else $error("retry count not reset on clear");

    property p_readback;
        @(posedge ref_clk) disable iff (sys_rst)
        (cmdValid && cmdWrite && cmdCode == CMD_REACTION) ##1 !cmdValid ##1
        (cmdValid && !cmdWrite && cmdCode == CMD_REACTION)
        |=> rdValid && rdData[7:0] == $past(cmdWdata[7:0], 3);
    endproperty
    a_readback: assert property (p_readback)
        else $error("reaction byte readback mismatch");

    property p_status;
        @(posedge ref_clk) disable iff (sys_rst)
        overTemp |=> otFault;
    endproperty
    a_status: assert property (p_status)
        else $error("fault status not set");

    c_latch: cover property (@(posedge ref_clk) state == ST_LATCHED);
    c_attempt_ok: cover property (@(posedge ref_clk)
        state == ST_ATTEMPT ##1 state == ST_RUN);
    c_cont: cover property (@(posedge ref_clk)
        state == ST_CONT_DELAY ##1 state == ST_RETRY_WAIT);
endmodule

// >>> verilog/ofr_pkg.sv
package ofr_pkg;
    localparam logic [7:0]  CMD_REACTION   = 8'h50;
    localparam logic [7:0]  CMD_OT_LIMIT   = 8'h4F;
    localparam logic [7:0]  REACTION_RESET = 8'h80;
    localparam logic [15:0] LIMIT_RESET    = 16'h7FFF;
    localparam int          RESP_HI        = 7;
    localparam int          RESP_LO        = 6;
    localparam int          RETRY_HI       = 5;
    localparam int          RETRY_LO       = 3;
    localparam int          DELAY_HI       = 2;
    localparam int          DELAY_LO       = 0;
    localparam logic [1:0]  RESP_IGNORE    = 2'h0;
    localparam logic [1:0]  RESP_CONTINUE  = 2'h1;
    localparam logic [1:0]  RESP_DISABLE   = 2'h2;
    localparam logic [1:0]  RESP_LATCH     = 2'h3;
    localparam logic [2:0]  RETRY_NONE     = 3'h0;
    localparam logic [2:0]  RETRY_FOREVER  = 3'h7;
    localparam int          UNIT_W         = 16;
    localparam int          DELAY_MAX_SH   = 7;

    typedef enum logic [2:0]
    {
        ST_OFF,
        ST_RUN,
        ST_CONT_DELAY,
        ST_RETRY_WAIT,
        ST_ATTEMPT,
        ST_LATCHED
    } ofr_state_e;
endpackage

// >>> verilog/ofr_timer_if.sv
`timescale 1ns/1ns
interface ofr_timer_if;
    import ofr_pkg::*;
    logic              start;
    logic [2:0]        delayCode;
    logic [UNIT_W-1:0] unitLen;
    logic              expired;
    modport ctrl  (output start, output delayCode, output unitLen,
                   input expired);
    modport timer (input start, input delayCode, input unitLen,
                   output expired);
endinterface
